// >>> design/udpm_counter.sv
`timescale 1ns/100ps
// Saturating idle-time counter; clear restarts from zero
module udpm_counter
  import udpm_pkg::*;
#(
  parameter int WIDTH = 20
)
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic clear_in,
  output logic [WIDTH-1:0] count_out
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  always_comb
  begin
    count_next = count_reg;
    if (clear_in)
      count_next = '0;
    else if (count_reg != {WIDTH{1'b1}})
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      count_reg <= '0;
    else if (clk_en_in)
      count_reg <= count_next;
  end

  assign count_out = count_reg;
endmodule // udpm_counter

// >>> design/udpm_power_mgmt.sv
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "udpm_defines.svh"
module udpm_power_mgmt
  import udpm_pkg::*;
#(
  parameter int NUM_EP = 4,
  parameter int IDLE_CYC = `UDPM_IDLE_CYC,
  parameter int J_WAIT_CYC = `UDPM_J_WAIT_CYC,
  parameter int RESET_SE0_CYC = `UDPM_RESET_SE0_CYC,
  parameter int RESUME_K_CYC = `UDPM_RESUME_K_CYC
)
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [1:0] line_state_in,
  input wire logic bus_activity_in,
  input wire logic hs_chirp_ok_in,
  input wire logic wakeup_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic suspend_n_out,
  output logic usb_reset_out,
  output logic xcvr_select_out,
  output logic term_select_out,
  output logic drive_resume_k_out,
  output logic common_bus_mode_out,
  output logic [NUM_EP-1:0] endpoint_init_cmd_out,
  output logic [NUM_EP*11-1:0] endpoint_packet_size_out
);
  localparam int CW = 24;

  typedef struct packed {
    udpm_state_t state;
    logic hs_mode;
    logic hs_before;
    logic usb_reset;
    logic suspend_n;
    udpm_phy_ctl_t phy;
    logic common_bus;
    logic remote_wake_en;
    logic [3:0] events;
    logic [NUM_EP-1:0] ep_init;
    logic [NUM_EP-1:0][7:0] ep_status;
    logic [NUM_EP-1:0][`UDPM_PKT_MSB:0] endpoint_packet_size_reg;
    logic [31:0] rdata;
    udpm_line_t line_prev;
  } udpm_state_reg_t;

  udpm_state_reg_t st_reg;
  udpm_state_reg_t st_next;
  udpm_bus_req_t req;
  logic [1:0] line_s1_reg;
  logic [1:0] line_s2_reg;
  logic wake_s1_reg;
  logic wake_s2_reg;
  logic [CW-1:0] cnt;
  logic cnt_clear;
  udpm_line_t line;

  // Pins cross from the PHY domain
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      line_s1_reg <= 2'h1;
      line_s2_reg <= 2'h1;
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
    end
    else if (clk_en_in)
    begin
      line_s1_reg <= line_state_in;
      line_s2_reg <= line_s1_reg;
      wake_s1_reg <= wakeup_in;
      wake_s2_reg <= wake_s1_reg;
    end
  end

  assign line = udpm_line_t'(line_s2_reg);
  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  function automatic logic is_ep_addr(input logic [3:0] a);
    return a >= `UDPM_ADDR_EP_BASE && a < `UDPM_ADDR_EP_BASE + 4'(NUM_EP);
  endfunction

  udpm_counter #(.WIDTH(CW)) u_idle_cnt (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .clear_in(cnt_clear),
    .count_out(cnt)
  );

  function automatic udpm_state_reg_t reg_init();
    udpm_state_reg_t r;
    r = '0;
    r.state = UDPM_ST_ACTIVE;
    r.suspend_n = 1'b1;
    r.common_bus = 1'b1;
    r.phy.xcvr_select = 1'b1;
    r.line_prev = UDPM_LS_J;
    return r;
  endfunction

  always_comb
  begin
    st_next = st_reg;
    cnt_clear = 1'b0;
    st_next.ep_init = '0;
    st_next.rdata = '0;
    unique case (st_reg.state)
      UDPM_ST_ACTIVE:
      begin
        // New line state restarts timing, so J time never counts as SE0
        if (line != st_reg.line_prev)
          cnt_clear = 1'b1;
        if (bus_activity_in || line != (st_reg.hs_mode ? UDPM_LS_SE0 : UDPM_LS_J))
        begin
          if (line == UDPM_LS_SE0 && !st_reg.hs_mode && !bus_activity_in)
          begin
            if (cnt >= CW'(RESET_SE0_CYC) && line == st_reg.line_prev)
            begin
              st_next.state = UDPM_ST_RESET;
              st_next.usb_reset = 1'b1;
              st_next.events[`UDPM_EV_RST_BEGIN] = 1'b1;
            end
          end
          else
            cnt_clear = 1'b1;
        end
        else if (st_reg.hs_mode && cnt >= CW'(IDLE_CYC))
        begin
          st_next.state = UDPM_ST_FALLBACK;
          st_next.hs_before = 1'b1;
          st_next.hs_mode = 1'b0;
          st_next.phy.xcvr_select = 1'b1;
          st_next.phy.term_select = 1'b1;
          cnt_clear = 1'b1;
        end
        else if (!st_reg.hs_mode && cnt >= CW'(IDLE_CYC))
        begin
          st_next.state = UDPM_ST_SUSPEND;
          st_next.hs_before = 1'b0;
          st_next.suspend_n = 1'b0;
          st_next.events[`UDPM_EV_SUSPEND] = 1'b1;
        end
      end
      UDPM_ST_FALLBACK:
      begin
        if (line == UDPM_LS_J)
        begin
          st_next.state = UDPM_ST_SUSPEND;
          st_next.suspend_n = 1'b0;
          st_next.events[`UDPM_EV_SUSPEND] = 1'b1;
        end
        else if (cnt >= CW'(J_WAIT_CYC))
        begin
          st_next.state = UDPM_ST_RESET;
          st_next.usb_reset = 1'b1;
          st_next.events[`UDPM_EV_RST_BEGIN] = 1'b1;
        end
      end
      UDPM_ST_RESET:
      begin
        if (hs_chirp_ok_in)
          st_next.hs_mode = 1'b1;
        if (line != UDPM_LS_SE0)
        begin
          st_next = reg_init();
          st_next.hs_mode = st_reg.hs_mode | hs_chirp_ok_in;
          st_next.phy.term_select = 1'b1;
          st_next.phy.xcvr_select = ~(st_reg.hs_mode | hs_chirp_ok_in);
          st_next.events = st_reg.events;
          st_next.events[`UDPM_EV_RST_END] = 1'b1;
          cnt_clear = 1'b1;
        end
        else
        begin
          st_next.ep_status = '0;
          st_next.common_bus = 1'b1;
        end
      end
      UDPM_ST_SUSPEND:
      begin
        cnt_clear = 1'b1;
        if (line == UDPM_LS_K)
        begin
          st_next.state = UDPM_ST_RESUME_WAIT;
          st_next.suspend_n = 1'b1;
          st_next.events[`UDPM_EV_RESUME] = 1'b1;
        end
        else if (wake_s2_reg && st_reg.remote_wake_en)
        begin
          st_next.state = UDPM_ST_RESUME_K;
          st_next.suspend_n = 1'b1;
          st_next.phy.drive_k = 1'b1;
          st_next.events[`UDPM_EV_RESUME] = 1'b1;
        end
      end
      UDPM_ST_RESUME_K:
      begin
        if (cnt >= CW'(RESUME_K_CYC))
        begin
          st_next.phy.drive_k = 1'b0;
          st_next.state = UDPM_ST_RESUME_WAIT;
          cnt_clear = 1'b1;
        end
      end
      UDPM_ST_RESUME_WAIT:
      begin
        cnt_clear = 1'b1;
        if (line == UDPM_LS_SE0)
        begin
          st_next.state = UDPM_ST_ACTIVE;
          st_next.hs_mode = st_reg.hs_before;
          st_next.phy.xcvr_select = ~st_reg.hs_before;
          st_next.phy.term_select = 1'b1;
        end
      end
    endcase
    st_next.line_prev = line;

    // Writes while reset is high are accepted; at its end all but event clears and last-cycle writes are wiped
    if (req.wr)
    begin
      unique case (1'b1)
        req.addr == `UDPM_ADDR_CTRL:
        begin
          st_next.remote_wake_en = req.wdata[0];
          st_next.common_bus = req.wdata[1];
        end
        // Write-one-to-clear; a same-cycle event wins only if its flag was clear
        req.addr == `UDPM_ADDR_EVENT:
          st_next.events = st_next.events & ~(req.wdata[3:0] & ~(st_next.events ^ st_reg.events));
        req.addr == `UDPM_ADDR_CMD:
        begin
          if (req.wdata[7:0] == `UDPM_CMD_EP_INIT)
          begin
            st_next.ep_init = '1;
            st_next.ep_status = '0;
          end
        end
        is_ep_addr(req.addr):
          st_next.endpoint_packet_size_reg[req.addr - `UDPM_ADDR_EP_BASE] =
            req.wdata[`UDPM_PKT_MSB:0];
        default:
        begin
        end
      endcase
    end
    if (req.rd)
    begin
      if (req.addr == `UDPM_ADDR_CTRL)
        st_next.rdata = {30'h0, st_reg.common_bus, st_reg.remote_wake_en};
      else if (req.addr == `UDPM_ADDR_STATUS)
        st_next.rdata = {26'h0, st_reg.phy.drive_k, st_reg.phy.term_select,
          st_reg.phy.xcvr_select, st_reg.usb_reset, st_reg.suspend_n, st_reg.hs_mode};
      else if (req.addr == `UDPM_ADDR_EVENT)
        st_next.rdata = {28'h0, st_reg.events};
      else if (is_ep_addr(req.addr))
        st_next.rdata = {21'h0, st_reg.endpoint_packet_size_reg[req.addr - `UDPM_ADDR_EP_BASE]};
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      st_reg <= reg_init();
    else if (clk_en_in)
      st_reg <= st_next;
  end

  // suspend output held high from reset
  assign suspend_n_out = st_reg.suspend_n;
  assign usb_reset_out = st_reg.usb_reset;
  assign xcvr_select_out = st_reg.phy.xcvr_select;
  assign term_select_out = st_reg.phy.term_select;
  assign drive_resume_k_out = st_reg.phy.drive_k;
  assign common_bus_mode_out = st_reg.common_bus;
  assign endpoint_init_cmd_out = st_reg.ep_init;
  assign endpoint_packet_size_out = st_reg.endpoint_packet_size_reg;
  assign reg_rdata_out = st_reg.rdata;
endmodule // udpm_power_mgmt

// >>> dv/udpm_host_model.sv
`timescale 1ns/100ps
module udpm_host_model (
  input wire logic core_clk_in,
  input wire logic [1:0] mode_in,
  input wire logic want_hs_in,
  input wire logic usb_reset_in,
  output logic [1:0] line_state_out,
  output logic bus_activity_out,
  output logic hs_chirp_ok_out
);
  // Mode 3 is packet traffic, else a held line state
  always_ff @(posedge core_clk_in)
  begin
    bus_activity_out <= (mode_in == 2'h3);
    line_state_out <= (mode_in == 2'h3) ? 2'h1 + 2'($urandom_range(1)) : mode_in;
    // Host chirps only while reset is signalled
    hs_chirp_ok_out <= want_hs_in && usb_reset_in;
  end
endmodule // udpm_host_model

// >>> dv/udpm_monitor.sv
`timescale 1ns/100ps
module udpm_monitor #(
  parameter int NUM_EP = 4,
  parameter int IDLE_CYC = 50,
  parameter int RESET_SE0_CYC = 30,
  parameter int RESUME_K_CYC = 40
)
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [1:0] line_state_in,
  input wire logic bus_activity_in,
  input wire logic suspend_n_out,
  input wire logic usb_reset_out,
  input wire logic xcvr_select_out,
  input wire logic term_select_out,
  input wire logic drive_resume_k_out,
  input wire logic common_bus_mode_out,
  input wire logic [NUM_EP*11-1:0] endpoint_packet_size_out
);
  logic [15:0] se0_reg, qt_reg, kc_reg;
  always_ff @(posedge core_clk_in)
  begin
    // Pin-side counts lead the synchronised ones
    se0_reg <= (reset_in || line_state_in != 2'h0) ? 16'h0 : se0_reg + 16'h1;
    qt_reg <= (reset_in || bus_activity_in || line_state_in == 2'h2) ? 16'h0 : qt_reg + 16'h1;
    kc_reg <= (reset_in || !drive_resume_k_out) ? 16'h0 : kc_reg + 16'h1;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_k_end; $fell(drive_resume_k_out); endsequence
  property p_init;
    disable iff (1'b0) $fell(reset_in) |-> (suspend_n_out && !usb_reset_out && xcvr_select_out
      && !term_select_out && common_bus_mode_out);
  endproperty
  a_init: assert property (p_init) else $error("outputs off after reset");
  property p_rec; $rose(usb_reset_out) |-> se0_reg >= RESET_SE0_CYC; endproperty
  a_rec: assert property (p_rec) else $error("bus reset too early");
  property p_end;
    $fell(usb_reset_out) |-> ##[0:2] (common_bus_mode_out && endpoint_packet_size_out == '0);
  endproperty
  a_end: assert property (p_end) else $error("no reinit at reset end");
  property p_sus; $fell(suspend_n_out) |-> qt_reg >= IDLE_CYC; endproperty
  a_sus: assert property (p_sus) else $error("suspend too early");
  // Reset end may also raise term_select; only idle fallback raises xcvr_select and is timed
  property p_fb;
    $rose(xcvr_select_out) && term_select_out && !$past(usb_reset_out) |-> se0_reg >= IDLE_CYC;
  endproperty
  a_fb: assert property (p_fb) else $error("fallback too early");
  property p_res; !suspend_n_out && line_state_in == 2'h2 |-> ##[1:6] suspend_n_out; endproperty
  a_res: assert property (p_res) else $error("no resume on K");
  property p_kd; s_k_end |-> kc_reg >= RESUME_K_CYC - 1 && kc_reg <= RESUME_K_CYC + 1; endproperty
  a_kd: assert property (p_kd) else $error("resume K length wrong");
  property p_keep;
    !suspend_n_out |=> $stable(endpoint_packet_size_out) && $stable(xcvr_select_out);
  endproperty
  a_keep: assert property (p_keep) else $error("state lost in suspend");
endmodule // udpm_monitor

// >>> dv/usb_device_power_mgmt_test.sv
`timescale 1ns/100ps
module usb_device_power_mgmt_test
  import udpm_pkg::*;
;
  localparam int IDL = 50;
  localparam int JW = 20;
  localparam int RSE = 30;
  localparam int RK = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic wake = 1'b0;
  logic hs = 1'b0;
  logic [1:0] mode = 2'h3;
  udpm_bus_req_t bus = '0;
  logic [1:0] line;
  logic act, chirp, sus_n, ures, xcvr, term, dk;
  logic [31:0] rdata, rv;
  logic [31:0] sz [4];
  logic [3:0] init;
  logic [43:0] psz;
  int n_mismatch = 0;
  int comparisons = 0;
  wire [3:0] mon = {xcvr & term, dk, ures, sus_n};
  always #2.5 clk = ~clk;
  udpm_host_model i_host (.core_clk_in(clk), .mode_in(mode), .want_hs_in(hs),
    .usb_reset_in(ures), .line_state_out(line), .bus_activity_out(act), .hs_chirp_ok_out(chirp));
  udpm_power_mgmt #(.IDLE_CYC(IDL), .J_WAIT_CYC(JW), .RESET_SE0_CYC(RSE), .RESUME_K_CYC(RK)) i_dut (
    .core_clk_in(clk), .reset_in(rst), .clk_en_in(clk_en), .line_state_in(line),
    .bus_activity_in(act), .hs_chirp_ok_in(chirp), .wakeup_in(wake), .reg_addr_in(bus.addr),
    .reg_wdata_in(bus.wdata), .reg_wr_in(bus.wr), .reg_rd_in(bus.rd), .reg_rdata_out(rdata),
    .suspend_n_out(sus_n), .usb_reset_out(ures), .xcvr_select_out(xcvr), .term_select_out(term),
    .drive_resume_k_out(dk), .common_bus_mode_out(), .endpoint_init_cmd_out(init),
    .endpoint_packet_size_out(psz));
  task automatic conclude;
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask
  task automatic waitfor(input int sel, input logic lvl, input int lim);
    repeat (lim)
      if (mon[sel] !== lvl)
        @(negedge clk);
    chk(32'(mon[sel]), 32'(lvl));
    @(posedge clk);
  endtask
  task automatic host_end;
    mode <= 2'h0;
    repeat (3) @(posedge clk);
    mode <= 2'h3;
    repeat (3) @(posedge clk);
  endtask
  task automatic sizes(input logic w);
    for (int i = 0; i < 4; i++)
    begin
      if (w)
      begin
        // even size stands in for an odd one
        sz[i] = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h400 : $urandom;
        wr(4'h8 + 4'(i), sz[i]);
      end
      else
      begin
        rd(4'h8 + 4'(i));
        chk(rv, sz[i] & 32'h7ff);
        chk(32'(psz[i*11 +: 11]), sz[i] & 32'h7ff);
      end
    end
  endtask
  function automatic logic [31:0] st_exp(input logic h, input logic t);
    return {26'h0, 1'b0, t, ~h, 1'b0, 1'b1, h};
  endfunction
  initial
  begin
    void'($urandom(32'hd1cddf38));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(4'h1);
    chk(rv, st_exp(1'b0, 1'b0));
    rd(4'hf);
    chk(rv, 32'h0);
    sizes(1'b1);
    sizes(1'b0);
    @(posedge clk);
    mode <= 2'h0;
    waitfor(1, 1'b1, RSE + 10);
    wr(4'h8, 32'h3fe);
    wr(4'h0, 32'h1);
    mode <= 2'h3;
    waitfor(1, 1'b0, 10);
    rd(4'h8);
    chk(rv, 32'h0);
    rd(4'h0);
    chk(rv, 32'h2);
    rd(4'h2);
    chk(rv & 32'hc, 32'hc);
    wr(4'h2, 32'hf);
    wr(4'h3, 32'h1);
    @(negedge clk);
    chk(32'(init), 32'hf);
    wr(4'h0, 32'h1);
    sizes(1'b1);
    mode <= 2'h1;
    waitfor(0, 1'b0, IDL + 10);
    rd(4'h2);
    chk(rv & 32'h1, 32'h1);
    @(posedge clk);
    clk_en <= 1'b0;
    repeat (5) @(posedge clk);
    clk_en <= 1'b1;
    mode <= 2'h2;
    waitfor(0, 1'b1, 8);
    host_end;
    sizes(1'b0);
    rd(4'h1);
    chk(rv, st_exp(1'b0, 1'b1));
    @(posedge clk);
    mode <= 2'h1;
    waitfor(0, 1'b0, IDL + 10);
    repeat (20) @(posedge clk);
    wake <= 1'b1;
    waitfor(2, 1'b1, 10);
    wake <= 1'b0;
    chk(32'(sus_n), 32'h1);
    waitfor(2, 1'b0, RK + 5);
    host_end;
    wr(4'h0, 32'h0);
    mode <= 2'h1;
    waitfor(0, 1'b0, IDL + 10);
    wake <= 1'b1;
    repeat (20) @(negedge clk);
    // Full-speed selects stay high while suspended
    chk(32'(mon), 32'h8);
    @(posedge clk);
    wake <= 1'b0;
    mode <= 2'h2;
    waitfor(0, 1'b1, 8);
    host_end;
    hs <= 1'b1;
    mode <= 2'h0;
    waitfor(1, 1'b1, RSE + 10);
    mode <= 2'h3;
    waitfor(1, 1'b0, 10);
    hs <= 1'b0;
    rd(4'h1);
    chk(rv, st_exp(1'b1, 1'b1));
    @(posedge clk);
    mode <= 2'h0;
    waitfor(3, 1'b1, IDL + 10);
    mode <= 2'h1;
    waitfor(0, 1'b0, JW + 10);
    mode <= 2'h2;
    waitfor(0, 1'b1, 8);
    host_end;
    rd(4'h1);
    chk(rv, st_exp(1'b1, 1'b1));
    @(posedge clk);
    mode <= 2'h0;
    waitfor(1, 1'b1, IDL + JW + 10);
    conclude;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude;
  end
endmodule // usb_device_power_mgmt_test
bind udpm_power_mgmt udpm_monitor #(.NUM_EP(NUM_EP), .IDLE_CYC(IDLE_CYC),
  .RESET_SE0_CYC(RESET_SE0_CYC), .RESUME_K_CYC(RESUME_K_CYC)) i_mon (.core_clk_in, .reset_in,
  .line_state_in, .bus_activity_in, .suspend_n_out, .usb_reset_out, .xcvr_select_out,
  .term_select_out, .drive_resume_k_out, .common_bus_mode_out, .endpoint_packet_size_out);

// >>> inc/udpm_defines.svh
// Operation
// - Bus reset end reinitialises all registers; the code keeps the event flags
// - Bus reset clears endpoint status, common access
// - HS SE0 over 3 ms: fall to FS
// - J after fallback declares suspend, SE0 reset
// - FS J idle over 3 ms: suspend
// - Suspend output high until host suspends
// - Registers and flags kept across suspend
// - Host K raises suspend output clocklessly; the code registers it on core_clk_in with clk_en_in
// - After resume keep previous bus speed
// - Wakeup raises suspend output without clock; the code samples wakeup_in through two clocked stages
// - Drive resume K about 2 ms
// - Packet size field is bits 10:0
// - SE0 over 68 us is bus reset
`ifndef UDPM_DEFINES_SVH
`define UDPM_DEFINES_SVH
`define UDPM_CLK_MHZ 200
`define UDPM_IDLE_US 3000
`define UDPM_FALLBACK_MAX_US 3125
`define UDPM_J_WAIT_US 110
`define UDPM_RESET_SE0_US 68
`define UDPM_RESUME_K_US 2000
`define UDPM_IDLE_CYC (`UDPM_IDLE_US * `UDPM_CLK_MHZ)
`define UDPM_J_WAIT_CYC (`UDPM_J_WAIT_US * `UDPM_CLK_MHZ)
`define UDPM_RESET_SE0_CYC (`UDPM_RESET_SE0_US * `UDPM_CLK_MHZ)
`define UDPM_RESUME_K_CYC (`UDPM_RESUME_K_US * `UDPM_CLK_MHZ)
`define UDPM_ADDR_CTRL 4'h0
`define UDPM_ADDR_STATUS 4'h1
`define UDPM_ADDR_EVENT 4'h2
`define UDPM_ADDR_CMD 4'h3
`define UDPM_ADDR_EP_BASE 4'h8
`define UDPM_PKT_MSB 10
`define UDPM_CMD_EP_INIT 8'h01
`define UDPM_EV_SUSPEND 0
`define UDPM_EV_RESUME 1
`define UDPM_EV_RST_BEGIN 2
`define UDPM_EV_RST_END 3
`endif

// >>> inc/udpm_pkg.sv
package udpm_pkg;
  typedef enum logic [1:0] {UDPM_LS_SE0, UDPM_LS_J, UDPM_LS_K, UDPM_LS_SE1} udpm_line_t;
  typedef enum {UDPM_ST_ACTIVE, UDPM_ST_FALLBACK, UDPM_ST_RESET, UDPM_ST_SUSPEND,
    UDPM_ST_RESUME_K, UDPM_ST_RESUME_WAIT} udpm_state_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } udpm_bus_req_t;
  typedef struct packed {
    logic xcvr_select;
    logic term_select;
    logic drive_k;
  } udpm_phy_ctl_t;
endpackage
